//--- core/swk_payload_trim_regs.sv
// Selective-wake payload, FD tolerance and oscillator trim register bank
//
// What this block does
// - Four read-write payload bytes, bit0 least significant
// - Power-on or soft reset clears payload bytes
// - FD bit 0 enables tolerant mode
// - Bits 3:1 pick dominant filter time
// - Bit 4 bypasses analog receive filter
// - Digital dominant filter ignores analog bypass
// - Bit 5 with FD stops error counting
// - Silence timeout clears error-count disable bit
// - Reserved bits read zero, ignore writes
// - Low trim writable only when unlocked
// - Trim bits 4:0 are monotonic fine steps
// - Options bits 4:0 hold gated trim 12:8
// - Options bit 7 picks wake receiver, gated
`timescale 1ns/1ns
`include "swk_regs_map.svh"
module swk_payload_trim_regs (
	// Clock and reset
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_resetn,
	input  wire logic                 i_soft_reset,
	// Register access port
	input  wire logic                 i_reg_wr,
	input  wire logic                 i_reg_rd,
	input  wire swk_pkg::reg_addr_t   i_reg_addr,
	input  wire swk_pkg::reg_byte_t   i_reg_wdata,
	output swk_pkg::reg_byte_t        o_reg_rdata,
	// Trim unlock field and bus silence timeout
	input  wire logic [1:0]           i_trim_unlock,
	input  wire logic                 i_silence_expired,
	// Receive pin
	input  wire logic                 i_rx_raw,
	// Payload bytes to the frame matcher
	output swk_pkg::reg_byte_t        o_payload_byte_zero,
	output swk_pkg::reg_byte_t        o_payload_byte_one,
	output swk_pkg::reg_byte_t        o_payload_byte_two,
	output swk_pkg::reg_byte_t        o_payload_byte_three,
	// FD tolerance controls
	output logic                      o_fd_tolerant_enable,
	output swk_pkg::glitch_code_t     o_dominant_glitch_time,
	output logic                      o_analog_rx_filter_skip,
	output logic                      o_frame_error_count_en,
	output logic                      o_rx_filtered,
	// Oscillator and receiver choice
	output swk_pkg::trim_word_t       o_osc_freq_adjust,
	output logic                      o_wake_receiver_choice
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	swk_pkg::reg_byte_t    payload [4];
	logic [5:0]            fd_cfg;
	swk_pkg::reg_byte_t    trim_low;
	logic [4:0]            trim_high;
	logic                  rx_sel;
	logic                  err_cnt_en;
	logic                  unlocked;
	logic                  fd_wr;
	logic                  trim_low_wr;
	logic                  opt_wr;
	swk_pkg::reg_byte_t    next_rdata;
	swk_pkg::reg_byte_t    rdata;

	glitch_if              glitch ();

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	// unlock key
	assign unlocked    = (i_trim_unlock == `TRIM_UNLOCK);
	assign fd_wr       = i_reg_wr && (i_reg_addr == `OFS_FD_CFG);
	assign trim_low_wr = i_reg_wr && (i_reg_addr == `OFS_TRIM_LOW);
	assign opt_wr      = i_reg_wr && (i_reg_addr == `OFS_RX_TRIM_HI);

	// ----------------------------------------
	// Payload bytes, index 0 is byte zero
	// ----------------------------------------
	// Byte zero sits at the highest offset, so the offset counts down
	for (genvar b = 0; b < 4; b++) begin : g_payload
		localparam swk_pkg::reg_addr_t OFS = swk_pkg::reg_addr_t'(`OFS_PAYLOAD0 - b);
		always_ff @(posedge i_sys_clk or negedge i_resetn) begin
			if (!i_resetn) begin
				payload[b] <= `PAYLOAD_RST;
			end else if (i_soft_reset) begin
				payload[b] <= `PAYLOAD_RST;
			end else if (i_reg_wr && (i_reg_addr == OFS)) begin
				payload[b] <= i_reg_wdata;
			end
		end
	end

	assign o_payload_byte_zero  = payload[0];
	assign o_payload_byte_one   = payload[1];
	assign o_payload_byte_two   = payload[2];
	assign o_payload_byte_three = payload[3];

	// ----------------------------------------
	// FD tolerance configuration
	// ----------------------------------------
	// Timeout clear beats a same-cycle write so the expiry is never missed
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			fd_cfg <= `FD_CFG_RST;
		end else if (i_soft_reset) begin
			fd_cfg <= `FD_CFG_RST;
		end else begin
			if (fd_wr) begin
				fd_cfg <= i_reg_wdata[5:0];
			end
			if (i_silence_expired) begin
				fd_cfg[`FD_ERR_OFF_BIT] <= 1'b0;
			end
		end
	end

	assign o_fd_tolerant_enable    = fd_cfg[`FD_EN_BIT];
	assign o_dominant_glitch_time  = fd_cfg[`FD_GLITCH_MSB:`FD_GLITCH_LSB];
	assign o_analog_rx_filter_skip = fd_cfg[`FD_SKIP_BIT];
	assign o_frame_error_count_en  = err_cnt_en;

	// Counting stops only when both the disable bit and FD mode are set
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			err_cnt_en <= 1'b1;
		end else begin
			err_cnt_en <= !(fd_cfg[`FD_ERR_OFF_BIT] && fd_cfg[`FD_EN_BIT]);
		end
	end

	// ----------------------------------------
	// Dominant glitch filter
	// ----------------------------------------
	// filter sees only the time code
	assign glitch.code   = o_dominant_glitch_time;
	assign o_rx_filtered = glitch.rx_filtered;

	dominant_glitch_filter u_glitch (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.i_rx_raw  (i_rx_raw),
		.glitch    (glitch.filt)
	);

	// ----------------------------------------
	// Oscillator trim and receiver choice
	// ----------------------------------------
	// Soft reset leaves trim alone: the oscillator must not jump mid-run
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			trim_low <= `TRIM_LOW_RST;
		end else if (trim_low_wr && unlocked) begin
			trim_low <= i_reg_wdata;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			trim_high <= `TRIM_HI_RST;
			rx_sel    <= `RX_SEL_RST;
		end else if (opt_wr && unlocked) begin
			trim_high <= i_reg_wdata[`OPT_TRIM_MSB:`OPT_TRIM_LSB];
			rx_sel    <= i_reg_wdata[`OPT_RX_SEL_BIT];
		end
	end

	assign o_osc_freq_adjust      = {trim_high, trim_low};
	assign o_wake_receiver_choice = rx_sel;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Unmapped offsets read zero; receiver bit hidden while locked
	always_comb begin
		next_rdata = `UNMAPPED_RD;
		case (i_reg_addr)
			`OFS_PAYLOAD0: begin
				next_rdata = payload[0];
			end
			`OFS_PAYLOAD1: begin
				next_rdata = payload[1];
			end
			`OFS_PAYLOAD2: begin
				next_rdata = payload[2];
			end
			`OFS_PAYLOAD3: begin
				next_rdata = payload[3];
			end
			`OFS_FD_CFG: begin
				next_rdata = {2'h0, fd_cfg};
			end
			`OFS_TRIM_LOW: begin
				next_rdata = trim_low;
			end
			`OFS_RX_TRIM_HI: begin
				next_rdata = {rx_sel && unlocked, 2'h0, trim_high};
			end
			default: begin
				next_rdata = `UNMAPPED_RD;
			end
		endcase
	end

	// Read data holds until the next read strobe
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata <= `UNMAPPED_RD;
		end else if (i_reg_rd) begin
			rdata <= next_rdata;
		end
	end

	assign o_reg_rdata = rdata;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_resetn);

	a_payload_store: assert property (
		(i_reg_wr && !i_soft_reset && i_reg_addr == 7'h33)
		|=> o_payload_byte_zero == $past(i_reg_wdata))
		else $error("payload byte zero did not take the write");

	a_soft_clear: assert property (
		i_soft_reset |=> (o_payload_byte_three == 8'h00
		&& o_payload_byte_zero == 8'h00 && !o_fd_tolerant_enable))
		else $error("soft reset did not clear payload and FD control");

	a_fd_enable: assert property (
		(fd_wr && !i_soft_reset) |=> o_fd_tolerant_enable == $past(i_reg_wdata[0]))
		else $error("FD enable does not follow the written bit");

	a_glitch_code: assert property (
		(fd_wr && !i_soft_reset) |=> o_dominant_glitch_time == $past(i_reg_wdata[3:1]))
		else $error("filter time code does not follow bits 3:1");

	a_skip_bit: assert property (
		(fd_wr && !i_soft_reset) |=> o_analog_rx_filter_skip == $past(i_reg_wdata[4]))
		else $error("analog bypass does not follow bit 4");

	// Long dominant must pass whatever the bypass bit says, so it is left out of the antecedent
	a_filter_indep: assert property (
		(u_glitch.state == swk_pkg::DOM_COUNT && !u_glitch.rx_level
		&& u_glitch.cnt >= u_glitch.limit_tab[o_dominant_glitch_time]) |=> !o_rx_filtered)
		else $error("digital filter did not pass a long dominant level");

	a_err_gate: assert property (
		(fd_cfg[5] && fd_cfg[0]) |=> !o_frame_error_count_en)
		else $error("error counting not stopped in FD mode");

	a_err_default: assert property (
		!(fd_cfg[5] && fd_cfg[0]) |=> o_frame_error_count_en)
		else $error("error counting stopped without FD mode");

	a_silence_clear: assert property (
		i_silence_expired |=> !fd_cfg[5] ##1 o_frame_error_count_en)
		else $error("silence timeout did not clear the disable bit");

	a_reserved_zero: assert property (
		(i_reg_rd && i_reg_addr == 7'h34) |=> o_reg_rdata[7:6] == 2'h0)
		else $error("reserved FD bits read non-zero");

	a_opt_reserved: assert property (
		(i_reg_rd && i_reg_addr == 7'h39) |=> o_reg_rdata[6:5] == 2'h0)
		else $error("reserved option bits read non-zero");

	a_trim_open: assert property (
		(trim_low_wr && i_trim_unlock == 2'h3)
		|=> o_osc_freq_adjust[7:0] == $past(i_reg_wdata))
		else $error("unlocked low trim write lost");

	a_fine_trim: assert property (
		(trim_low_wr && unlocked)
		|=> o_osc_freq_adjust[4:0] == $past(i_reg_wdata[4:0]))
		else $error("fine trim bits do not sit in bits 4:0");

	a_trim_high: assert property (
		(opt_wr && unlocked) |=> o_osc_freq_adjust[12:8] == $past(i_reg_wdata[4:0]))
		else $error("high trim write lost");

	a_rx_choice: assert property (
		(opt_wr && unlocked) |=> o_wake_receiver_choice == $past(i_reg_wdata[7]))
		else $error("receiver choice does not follow bit 7");

	a_locked_hold: assert property (
		((trim_low_wr || opt_wr) && !unlocked)
		|=> $stable(o_osc_freq_adjust) && $stable(o_wake_receiver_choice))
		else $error("locked write changed a gated field");

	a_read_data: assert property (
		(i_reg_rd && !i_reg_wr && !i_soft_reset && i_reg_addr == 7'h30)
		|=> o_reg_rdata == o_payload_byte_three)
		else $error("payload byte three read back wrong");

	a_rx_hidden: assert property (
		(i_reg_rd && !unlocked && i_reg_addr == `OFS_RX_TRIM_HI) |=> !o_reg_rdata[7])
		else $error("receiver choice visible while locked");

	a_unmapped_zero: assert property (
		(i_reg_rd && i_reg_addr == 7'h35) |=> o_reg_rdata == 8'h00)
		else $error("unmapped offset read non-zero");

	a_fd_readback: assert property (
		(i_reg_rd && !i_reg_wr && !i_soft_reset && !i_silence_expired && i_reg_addr == `OFS_FD_CFG)
		|=> o_reg_rdata[5:0] == fd_cfg)
		else $error("FD control read back wrong");

	a_trim_readback: assert property (
		(i_reg_rd && !i_reg_wr && i_reg_addr == `OFS_TRIM_LOW) |=> o_reg_rdata == o_osc_freq_adjust[7:0])
		else $error("low trim read back wrong");

	a_read_hold: assert property (
		!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("read data changed without a read strobe");

	c_payload_write: cover property (i_reg_wr && i_reg_addr == 7'h33);
	c_silence_clear: cover property (fd_cfg[5] ##1 i_silence_expired);
	c_unlocked_trim: cover property (opt_wr && unlocked);
	c_locked_trim: cover property (trim_low_wr && !unlocked);

endmodule // swk_payload_trim_regs

//--- core/swk_regs_map.svh
// Offsets, field positions, reset values and timing of the wake register bank
`ifndef SWK_REGS_MAP_SVH
`define SWK_REGS_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_PAYLOAD3   7'h30
`define OFS_PAYLOAD2   7'h31
`define OFS_PAYLOAD1   7'h32
`define OFS_PAYLOAD0   7'h33
`define OFS_FD_CFG     7'h34
`define OFS_TRIM_LOW   7'h38
`define OFS_RX_TRIM_HI 7'h39

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FD_EN_BIT      0
`define FD_GLITCH_LSB  1
`define FD_GLITCH_MSB  3
`define FD_SKIP_BIT    4
`define FD_ERR_OFF_BIT 5
`define OPT_TRIM_LSB   0
`define OPT_TRIM_MSB   4
`define OPT_RX_SEL_BIT 7
`define TRIM_UNLOCK    2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PAYLOAD_RST    8'h00
`define FD_CFG_RST     6'h00
`define TRIM_LOW_RST   8'h00
`define TRIM_HI_RST    5'h00
`define RX_SEL_RST     1'h0
`define UNMAPPED_RD    8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define SYS_CLK_PS     8000
`define DOM_STEP_NS    50
`define DOM_LONG_NS    775
`define DOM_LONG_CODE  7

`endif

//--- core/swk_pkg.sv
// Types shared by the wake register bank and its dominant filter
package swk_pkg;
	typedef logic [7:0]  reg_byte_t;
	typedef logic [6:0]  reg_addr_t;
	typedef logic [2:0]  glitch_code_t;
	typedef logic [6:0]  glitch_cnt_t;
	typedef logic [12:0] trim_word_t;
	typedef enum {REC_IDLE, DOM_COUNT, DOM_PASS} filt_state_t;
endpackage

//--- core/glitch_if.sv
// Link between the register bank and the dominant glitch filter
`timescale 1ns/1ns
interface glitch_if;
	swk_pkg::glitch_code_t code;
	logic                  rx_filtered;
	modport cfg  (output code, input rx_filtered);
	modport filt (input code, output rx_filtered);
endinterface

//--- core/dominant_glitch_filter.sv
// Digital dominant glitch filter on the synchronised receive pin
`timescale 1ns/1ns
`include "swk_regs_map.svh"
module dominant_glitch_filter (
	// Clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_resetn,
	// Raw receive pin, low is dominant
	input  wire logic i_rx_raw,
	// Filter time code in, filtered level out
	glitch_if.filt    glitch
);
	logic                 rx_meta;
	logic                 rx_s2;
	logic                 rx_s3;
	logic                 rx_level;
	swk_pkg::filt_state_t state;
	swk_pkg::glitch_cnt_t cnt;
	swk_pkg::glitch_cnt_t limit_tab [8];

	// ----------------------------------------
	// Cycle limits per time code, least times rounded up
	// ----------------------------------------
	for (genvar g = 0; g < 8; g++) begin : g_limit
		localparam int NS = (g == `DOM_LONG_CODE) ? `DOM_LONG_NS : `DOM_STEP_NS * (g + 1);
		assign limit_tab[g] = swk_pkg::glitch_cnt_t'((NS * 1000 + `SYS_CLK_PS - 1) / `SYS_CLK_PS);
	end

	// Three stages; level moves only when the last two agree
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rx_meta  <= 1'b1;
			rx_s2    <= 1'b1;
			rx_s3    <= 1'b1;
			rx_level <= 1'b1;
		end else begin
			rx_meta <= i_rx_raw;
			rx_s2   <= rx_meta;
			rx_s3   <= rx_s2;
			if (rx_s2 == rx_s3) begin
				rx_level <= rx_s3;
			end
		end
	end

	// Dominant passes only after it held for the limit; recessive passes at once
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state             <= swk_pkg::REC_IDLE;
			cnt               <= '0;
			glitch.rx_filtered <= 1'b1;
		end else begin
			case (state)
				swk_pkg::REC_IDLE: begin
					glitch.rx_filtered <= 1'b1;
					if (!rx_level) begin
						cnt   <= 7'h01;
						state <= swk_pkg::DOM_COUNT;
					end
				end
				swk_pkg::DOM_COUNT: begin
					if (rx_level) begin
						state <= swk_pkg::REC_IDLE;
					end else if (cnt >= limit_tab[glitch.code]) begin
						glitch.rx_filtered <= 1'b0;
						state              <= swk_pkg::DOM_PASS;
					end else begin
						cnt <= cnt + 7'h01;
					end
				end
				swk_pkg::DOM_PASS: begin
					if (rx_level) begin
						glitch.rx_filtered <= 1'b1;
						state              <= swk_pkg::REC_IDLE;
					end
				end
				default: begin
					state <= swk_pkg::REC_IDLE;
				end
			endcase
		end
	end

	a_long_limit: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) limit_tab[7] == 7'h61)
		else $error("longest dominant limit is not 97 cycles");
	a_dom_release: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(state == swk_pkg::DOM_PASS && rx_level) |=> glitch.rx_filtered)
		else $error("filtered output did not return recessive");
	c_dom_pass: cover property (@(posedge i_sys_clk) disable iff (!i_resetn) $fell(glitch.rx_filtered));
endmodule // dominant_glitch_filter

//--- sim/reg_host.sv
// Host-side model driving the register access port of the wake bank
`timescale 1ns/1ns
`include "swk_regs_map.svh"
module reg_host (
	// Clock
	input  wire logic               i_sys_clk,
	// Read data from the bank
	input  wire swk_pkg::reg_byte_t i_reg_rdata,
	// Strobes, address and write data
	output logic                    o_reg_wr,
	output logic                    o_reg_rd,
	output swk_pkg::reg_addr_t      o_reg_addr,
	output swk_pkg::reg_byte_t      o_reg_wdata
);
	// Quiet bus at time zero
	initial begin
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_addr = 7'h00;
		o_reg_wdata = 8'h00;
	end

	// Released lines flip so that stale data never passes for fresh data
	task automatic idle();
		o_reg_wr = 1'b0;
		o_reg_rd = 1'b0;
		o_reg_addr = ~o_reg_addr;
		o_reg_wdata = ~o_reg_wdata;
	endtask

	// One-cycle write strobe, launched on the falling edge
	task automatic wr(input swk_pkg::reg_addr_t a, input swk_pkg::reg_byte_t d);
		@(negedge i_sys_clk);
		o_reg_addr = a;
		o_reg_wdata = d;
		o_reg_wr = 1'b1;
		@(negedge i_sys_clk);
		idle();
	endtask

	// One-cycle read strobe, data taken once the edge has landed
	task automatic rd(input swk_pkg::reg_addr_t a, output swk_pkg::reg_byte_t d);
		@(negedge i_sys_clk);
		o_reg_addr = a;
		o_reg_rd = 1'b1;
		@(negedge i_sys_clk);
		d = i_reg_rdata;
		idle();
	endtask

	// receiver change, coarse trim written back unchanged
	task automatic set_receiver(input logic lp);
		swk_pkg::reg_byte_t v;
		rd(`OFS_RX_TRIM_HI, v);
		wr(`OFS_RX_TRIM_HI, {lp, v[6:0]});
	endtask

	// fine trim only, temperature bits kept as read
	task automatic set_fine(input logic [4:0] f);
		swk_pkg::reg_byte_t v;
		rd(`OFS_TRIM_LOW, v);
		wr(`OFS_TRIM_LOW, {v[7:5], f});
	endtask
endmodule // reg_host

//--- sim/test_swk_payload_trim_regs.sv
// Self-checking bench for the wake payload, FD and trim register bank
`timescale 1ns/1ns
`include "swk_regs_map.svh"
module test_swk_payload_trim_regs;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic                  i_sys_clk = 1'b0;
	logic                  i_resetn = 1'b0;
	logic                  i_soft_reset = 1'b0;
	logic                  i_silence_expired = 1'b0;
	logic                  i_rx_raw = 1'b1;
	logic [1:0]            i_trim_unlock = 2'h0;
	logic                  reg_wr, reg_rd;
	swk_pkg::reg_addr_t    reg_addr;
	swk_pkg::reg_byte_t    reg_wdata, rdata, pb0, pb1, pb2, pb3;
	logic                  fd_en, skip, cnt_en, rx_filt, rx_sel;
	swk_pkg::glitch_code_t glitch;
	swk_pkg::trim_word_t   osc;
	int                    n_mismatch = 0;
	int                    tests_run = 0;
	int unsigned           seed = 28777;
	int                    pay [$];
	int                    fd, tlo, thi, rxs, lim;

	// Free-running system clock, 8 ns period
	always #4 i_sys_clk = ~i_sys_clk;

	// ----------------------------------------
	// Design and host
	// ----------------------------------------
	swk_payload_trim_regs u_dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_soft_reset(i_soft_reset),
		.i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
		.o_reg_rdata(rdata), .i_trim_unlock(i_trim_unlock), .i_silence_expired(i_silence_expired),
		.i_rx_raw(i_rx_raw), .o_payload_byte_zero(pb0), .o_payload_byte_one(pb1),
		.o_payload_byte_two(pb2), .o_payload_byte_three(pb3), .o_fd_tolerant_enable(fd_en),
		.o_dominant_glitch_time(glitch), .o_analog_rx_filter_skip(skip), .o_frame_error_count_en(cnt_en),
		.o_rx_filtered(rx_filt), .o_osc_freq_adjust(osc), .o_wake_receiver_choice(rx_sel));
	reg_host u_host (.i_sys_clk(i_sys_clk), .i_reg_rdata(rdata), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
		.o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Fixed-seed xorshift keeps runs repeatable
	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [31:0] got, input int exp);
		tests_run++;
		if (got !== 32'(exp)) begin
			n_mismatch++;
			$display("BAD t=%0t got %h expected %h", $time, got, 32'(exp));
		end
	endtask

	task automatic rdchk(input swk_pkg::reg_addr_t a, input int exp);
		swk_pkg::reg_byte_t v;
		u_host.rd(a, v);
		chk({24'h000000, v}, exp);
	endtask

	// Write through the host and mirror the effect in the model
	task automatic mwr(input swk_pkg::reg_addr_t a, input swk_pkg::reg_byte_t d);
		u_host.wr(a, d);
		if (a >= `OFS_PAYLOAD3 && a <= `OFS_PAYLOAD0)
			pay[`OFS_PAYLOAD0 - a] = d;
		else if (a == `OFS_FD_CFG)
			fd = d & 8'h3F;
		else if (a == `OFS_TRIM_LOW && i_trim_unlock == `TRIM_UNLOCK)
			tlo = d;
		else if (a == `OFS_RX_TRIM_HI && i_trim_unlock == `TRIM_UNLOCK) begin
			thi = d & 8'h1F;
			rxs = d[7];
		end
	endtask

	// Read every register and compare every output except rx_filt with the model
	task automatic chk_all();
		for (int k = 0; k < 4; k++)
			rdchk(7'(`OFS_PAYLOAD0 - k), pay[k]);
		chk({pb3, pb2, pb1, pb0}, {pay[3][7:0], pay[2][7:0], pay[1][7:0], pay[0][7:0]});
		rdchk(`OFS_FD_CFG, fd);
		chk({fd_en, glitch, skip}, {fd[0], fd[3:1], fd[4]});
		chk(cnt_en, !(fd[5] && fd[0]));
		rdchk(`OFS_TRIM_LOW, tlo);
		rdchk(`OFS_RX_TRIM_HI, ((i_trim_unlock == `TRIM_UNLOCK) ? rxs << 7 : 0) | thi);
		chk(osc, (thi << 8) | tlo);
		chk(rx_sel, rxs);
		rdchk(7'h35, 0);
		rdchk(7'h7F, 0);
	endtask

	// Dominant pulse of n cycles; says whether the filtered level ever went low
	task automatic pulse(input int n, input int exp_low);
		logic seen;
		seen = 1'b0;
		@(negedge i_sys_clk);
		i_rx_raw = 1'b0;
		repeat (n) begin
			@(negedge i_sys_clk);
			if (rx_filt === 1'b0) seen = 1'b1;
		end
		i_rx_raw = 1'b1;
		// Sync stages still carry the pulse for a few cycles after release
		repeat (10) begin
			@(negedge i_sys_clk);
			if (rx_filt === 1'b0 && !exp_low) seen = 1'b1;
		end
		chk(seen, exp_low);
		chk(rx_filt, 1);
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		pay = '{0, 0, 0, 0};
		{fd, tlo, thi, rxs} = {32'h0, 32'h0, 32'h0, 32'h0};
		repeat (20) @(negedge i_sys_clk);
		i_resetn = 1'b1;
		chk_all();
		// Random payload bytes, one idle cycle between writes
		repeat (3) begin
			for (int k = 0; k < 4; k++)
				mwr(7'(`OFS_PAYLOAD3 + k), 8'(rnd()));
			chk_all();
		end
		repeat (4) begin
			mwr(`OFS_FD_CFG, 8'(rnd()));
			chk_all();
		end
		mwr(`OFS_FD_CFG, 8'hFF);
		chk_all();
		// Counting stays on unless tolerant mode is also enabled
		mwr(`OFS_FD_CFG, 8'h20);
		chk_all();
		mwr(`OFS_FD_CFG, 8'h21);
		chk_all();
		@(negedge i_sys_clk);
		i_silence_expired = 1'b1;
		@(negedge i_sys_clk);
		i_silence_expired = 1'b0;
		fd = fd & 8'h1F;
		chk_all();
		// Every unlock code, only binary 11 lets gated writes through
		for (int u = 0; u < 4; u++) begin
			i_trim_unlock = 2'(u);
			mwr(`OFS_TRIM_LOW, 8'(rnd()));
			mwr(`OFS_RX_TRIM_HI, 8'(rnd()));
			chk_all();
		end
		u_host.set_receiver(1'b1);
		rxs = 1;
		chk_all();
		lim = rnd() & 8'h1F;
		u_host.set_fine(5'(lim));
		tlo = (tlo & 8'hE0) | lim;
		chk_all();
		i_trim_unlock = 2'h2;
		chk_all();
		// Soft reset clears payload and FD but keeps trim
		@(negedge i_sys_clk);
		i_soft_reset = 1'b1;
		@(negedge i_sys_clk);
		i_soft_reset = 1'b0;
		pay = '{0, 0, 0, 0};
		fd = 0;
		chk_all();
		// Each filter code, bypass toggled alongside
		for (int c = 0; c < 8; c++) begin
			mwr(`OFS_FD_CFG, 8'((c << 1) | ((c & 1) << 4)));
			lim = (c == 7) ? (775 + 7) / 8 : (50 * (c + 1) + 7) / 8;
			pulse(lim / 2, 0);
			pulse(lim + 12, 1);
		end
		chk_all();
		final_report();
	end
endmodule // test_swk_payload_trim_regs
